// ### ssq_top.sv
// Strain bridge measurement sequencer with register port
`timescale 1ns/10ps
module ssq_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ssq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [31:0] rd_data_o,
  input wire logic comp_trip_i,
  input wire logic slow_osc_i,
  output logic discharge_o,
  output logic [2:0] gauge_sel_o,
  output logic hs_osc_en_o,
  output logic sleep_o
);
  ssq_pkg::ssq_cfg_s cfg;
  ssq_pkg::ssq_state_e state;
  ssq_pkg::ssq_state_e next_state;
  logic [1:0] pins_s;
  logic slow_d;
  logic tick;
  logic comp_s;
  logic [19:0] fast_cnt;
  logic [9:0] tick_cnt;
  logic [2:0] cyc_idx;
  logic [9:0] smp_cnt;
  logic [4:0] ext_cnt;
  logic in_extra;
  logic pair_odd;
  logic signed [35:0] acc;
  logic [23:0] bridge_result_word;
  logic new_result;
  logic overflow;
  logic stop_req;
  logic div_start;
  logic div_done;
  logic [35:0] div_q;
  logic [35:0] acc_mag;
  logic acc_neg;
  logic [23:0] sat_res;
  logic disch_end;
  logic last_disch;
  logic stretched;
  logic [19:0] cyc_lim;
  logic [19:0] disch_lim;
  logic [9:0] avr_eff;
  logic [4:0] extra_total;
  logic [9:0] pair_ticks;
  logic start_wr;
  logic res_rd;

  function automatic logic [2:0] bridge_last(input logic [1:0] bt);
    case (bt)
      2'd0: bridge_last = 3'd1;
      2'd1: bridge_last = 3'd3;
      default: bridge_last = 3'd7;
    endcase
  endfunction

  function automatic logic osc_on(input ssq_pkg::ssq_state_e st, input logic str);
    case (st)
      ssq_pkg::ST_SLEEP: osc_on = 1'b0;
      ssq_pkg::ST_GAP: osc_on = 1'b0;
      ssq_pkg::ST_DIV: osc_on = !str;
      default: osc_on = 1'b1;
    endcase
  endfunction

  ssq_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({slow_osc_i, comp_trip_i}),
    .sync_o(pins_s)
  );

  assign comp_s = pins_s[0];
  assign tick = pins_s[1] && !slow_d;
  assign stretched = cfg.stretch != 2'd0;
  assign cyc_lim = 20'(cfg.cytime * ssq_pkg::FAST_STEP_CYC);
  assign disch_lim = stretched ? ssq_pkg::DISCH_TIMEOUT_CYC : cyc_lim;
  assign avr_eff = (cfg.avrate == 10'd0) ? 10'd1 : cfg.avrate;
  assign extra_total = ssq_pkg::COMP_CYCLES + (5'd1 << cfg.mfake) + ssq_pkg::TEMP_CYCLES;
  assign pair_ticks = cfg.stretch[0] ? ssq_pkg::PAIR_GAP3_TICKS : ssq_pkg::PAIR_GAP2_TICKS;
  assign disch_end = (state == ssq_pkg::ST_DISCH) && (comp_s || fast_cnt >= disch_lim);
  assign last_disch = in_extra && (ext_cnt == extra_total - 5'd1);
  assign start_wr = wr_en_i && addr_i == ssq_pkg::OFF_CTRL && wr_data_i[ssq_pkg::POS_START];
  assign res_rd = rd_en_i && addr_i == ssq_pkg::OFF_RES;
  assign acc_neg = acc[35];
  assign acc_mag = acc_neg ? 36'(-acc) : 36'(acc);
  assign sat_res = acc_neg ? ((div_q > 36'h80_0000) ? ssq_pkg::RES_MIN : 24'(-div_q))
                           : ((div_q > 36'h7F_FFFF) ? ssq_pkg::RES_MAX : div_q[23:0]);

  ssq_div u_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(div_start),
    .dividend_i(acc_mag),
    .divisor_i(avr_eff),
    .done_o(div_done),
    .quotient_o(div_q)
  );

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg <= '{single_conv: 1'b0, stretch: 2'd0, cytime: ssq_pkg::RST_CYTIME, bridge: 2'd0,
               mfake: 2'd0, adjust: ssq_pkg::RST_ADJUST, lead: ssq_pkg::RST_LEAD,
               avrate: ssq_pkg::RST_AVRATE};
    end else if (wr_en_i) begin
      case (addr_i)
        ssq_pkg::OFF_MODE: begin
          cfg.single_conv <= wr_data_i[ssq_pkg::POS_SINGLE];
          cfg.cytime <= wr_data_i[ssq_pkg::POS_CYTIME +: 10];
          cfg.bridge <= wr_data_i[ssq_pkg::POS_BRIDGE +: 2];
          cfg.mfake <= wr_data_i[ssq_pkg::POS_MFAKE +: 2];
        end
        ssq_pkg::OFF_CFG3: begin
          cfg.adjust <= wr_data_i[ssq_pkg::POS_ADJUST +: 6];
          cfg.stretch <= wr_data_i[ssq_pkg::POS_STRETCH +: 2];
          cfg.lead <= wr_data_i[ssq_pkg::POS_LEAD +: 3];
        end
        ssq_pkg::OFF_AVG: cfg.avrate <= wr_data_i[9:0];
        default: ;
      endcase
    end
  end

  // Read port, unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= '0;
      if (rd_en_i) begin
        case (addr_i)
          ssq_pkg::OFF_MODE: rd_data_o <= 32'({cfg.mfake, cfg.bridge, cfg.cytime, 1'b0, cfg.single_conv, 2'b00});
          ssq_pkg::OFF_CFG3: rd_data_o <= 32'({cfg.lead, 3'b000, cfg.stretch, 2'b00, cfg.adjust, 4'h0});
          ssq_pkg::OFF_AVG: rd_data_o <= 32'(cfg.avrate);
          ssq_pkg::OFF_STAT: rd_data_o <= 32'({overflow, sleep_o, new_result, state != ssq_pkg::ST_SLEEP});
          ssq_pkg::OFF_RES: rd_data_o <= {8'h00, bridge_result_word};
          default: rd_data_o <= '0;
        endcase
      end
    end
  end

  // Sequencing state
  always_comb begin
    next_state = state;
    case (state)
      ssq_pkg::ST_SLEEP:
        if (start_wr) begin
          next_state = stretched ? ssq_pkg::ST_WARM : ssq_pkg::ST_DISCH;
        end
      ssq_pkg::ST_WARM:
        if (tick_cnt >= 10'(cfg.lead)) begin
          next_state = ssq_pkg::ST_DISCH;
        end
      ssq_pkg::ST_DISCH:
        if (disch_end) begin
          if (!stretched) begin
            next_state = ssq_pkg::ST_CHARGE;
          end else if (cfg.stretch != 2'd1 && !pair_odd && !last_disch) begin
            next_state = ssq_pkg::ST_PAIR;
          end else if (last_disch) begin
            next_state = ssq_pkg::ST_DIV;
          end else begin
            next_state = ssq_pkg::ST_GAP;
          end
        end
      ssq_pkg::ST_CHARGE:
        if (fast_cnt + 20'd1 >= cyc_lim) begin
          next_state = (in_extra && ext_cnt == extra_total) ? ssq_pkg::ST_DIV : ssq_pkg::ST_DISCH;
        end
      ssq_pkg::ST_PAIR:
        if (tick && tick_cnt + 10'd1 >= pair_ticks) begin
          next_state = ssq_pkg::ST_DISCH;
        end
      ssq_pkg::ST_GAP:
        if (tick && tick_cnt + 10'd1 >= cfg.cytime) begin
          next_state = ssq_pkg::ST_WARM;
        end
      ssq_pkg::ST_DIV:
        if (div_done) begin
          if (cfg.single_conv || stop_req) begin
            next_state = ssq_pkg::ST_SLEEP;
          end else begin
            next_state = stretched ? ssq_pkg::ST_GAP : ssq_pkg::ST_DISCH;
          end
        end
      default: next_state = ssq_pkg::ST_SLEEP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= ssq_pkg::ST_SLEEP;
      hs_osc_en_o <= 1'b0;
      sleep_o <= 1'b1;
      div_start <= 1'b0;
      slow_d <= 1'b0;
    end else begin
      state <= next_state;
      hs_osc_en_o <= osc_on(next_state, stretched);
      sleep_o <= next_state == ssq_pkg::ST_SLEEP;
      div_start <= next_state == ssq_pkg::ST_DIV && state != ssq_pkg::ST_DIV;
      slow_d <= pins_s[1];
    end
  end

  // Timers: fast from discharge start, slow ticks per wait state
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fast_cnt <= '0;
      tick_cnt <= '0;
    end else begin
      if (next_state == ssq_pkg::ST_DISCH && state != ssq_pkg::ST_DISCH) begin
        fast_cnt <= '0;
      end else if (fast_cnt != 20'hF_FFFF) begin
        fast_cnt <= fast_cnt + 20'd1;
      end
      if (next_state != state) begin
        tick_cnt <= '0;
      end else if (tick) begin
        tick_cnt <= tick_cnt + 10'd1;
      end
    end
  end

  // Discharge outputs
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      discharge_o <= 1'b0;
      gauge_sel_o <= '0;
    end else begin
      discharge_o <= next_state == ssq_pkg::ST_DISCH && !disch_end;
      gauge_sel_o <= in_extra ? 3'd0 : cyc_idx;
    end
  end

  // Position within the sequence
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cyc_idx <= '0;
      smp_cnt <= '0;
      ext_cnt <= '0;
      in_extra <= 1'b0;
      pair_odd <= 1'b0;
    end else if (state == ssq_pkg::ST_DIV || state == ssq_pkg::ST_SLEEP) begin
      cyc_idx <= '0;
      smp_cnt <= '0;
      ext_cnt <= '0;
      in_extra <= 1'b0;
      pair_odd <= 1'b0;
    end else if (disch_end) begin
      pair_odd <= !pair_odd;
      if (in_extra) begin
        ext_cnt <= ext_cnt + 5'd1;
      end else if (cyc_idx == bridge_last(cfg.bridge)) begin
        cyc_idx <= '0;
        if (smp_cnt + 10'd1 >= avr_eff) begin
          in_extra <= 1'b1;
        end else begin
          smp_cnt <= smp_cnt + 10'd1;
        end
      end else begin
        cyc_idx <= cyc_idx + 3'd1;
      end
    end
  end

  // Ratio accumulation: even gauge adds, odd gauge subtracts
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      acc <= '0;
      overflow <= 1'b0;
    end else begin
      if (state == ssq_pkg::ST_SLEEP && start_wr) begin
        overflow <= 1'b0;
      end else if (disch_end && !comp_s) begin
        overflow <= 1'b1;
      end
      if (div_done || state == ssq_pkg::ST_SLEEP) begin
        acc <= '0;
      end else if (disch_end && !in_extra) begin
        acc <= cyc_idx[0] ? acc - 36'(fast_cnt) : acc + 36'(fast_cnt);
      end
    end
  end

  // Result word, one LSB per 10 nV/V after calibration
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bridge_result_word <= '0;
      new_result <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      if (div_done) begin
        bridge_result_word <= sat_res;
      end
      if (div_done) begin
        new_result <= 1'b1;
      end else if (res_rd) begin
        new_result <= 1'b0;
      end
      if (wr_en_i && addr_i == ssq_pkg::OFF_CTRL && wr_data_i[ssq_pkg::POS_STOP]) begin
        stop_req <= 1'b1;
      end else if (state == ssq_pkg::ST_SLEEP) begin
        stop_req <= 1'b0;
      end
    end
  end

  // Checks
  logic [12:0] disch_seen;
  logic [12:0] disch_expect;
  assign disch_expect = 13'(13'(bridge_last(cfg.bridge)) + 13'd1) * 13'(avr_eff) + 13'(extra_total);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || state == ssq_pkg::ST_DIV || state == ssq_pkg::ST_SLEEP) begin
      disch_seen <= '0;
    end else if (disch_end) begin
      disch_seen <= disch_seen + 13'd1;
    end
  end

  sequence div_finish_s;
    div_done;
  endsequence

  sequence result_held_s;
    (bridge_result_word == $past(sat_res)) && new_result;
  endsequence

  seq_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state != ssq_pkg::ST_DIV && next_state == ssq_pkg::ST_DIV) |-> disch_seen + 13'(disch_end) == disch_expect)
    else $error("sequence ended with wrong discharge count");
  result_upd_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    div_finish_s |=> result_held_s)
    else $error("result not stored with new flag");
  new_flag_src_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(new_result) |-> $past(state) == ssq_pkg::ST_DIV)
    else $error("new result flag raised outside sequence end");
  sleep_osc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sleep_o |-> !hs_osc_en_o)
    else $error("oscillator on while asleep");
  cont_osc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!stretched && !sleep_o) |-> hs_osc_en_o)
    else $error("oscillator off in continuous run");
  gap_osc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == ssq_pkg::ST_GAP) |-> !hs_osc_en_o)
    else $error("oscillator on during stretch gap");
  warm_lead_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (stretched && $rose(state == ssq_pkg::ST_DISCH)) |-> $past(state) inside {ssq_pkg::ST_WARM, ssq_pkg::ST_PAIR})
    else $error("stretched discharge without oscillator lead");
  single_sleep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (div_done && cfg.single_conv) |=> sleep_o ##1 sleep_o)
    else $error("single conversion did not sleep");
  no_pause_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == ssq_pkg::ST_CHARGE && fast_cnt + 20'd1 >= cyc_lim && !(in_extra && ext_cnt == extra_total))
    |=> state == ssq_pkg::ST_DISCH)
    else $error("continuous mode paused between discharges");
  res_range_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    div_done && !acc_neg |-> !sat_res[23])
    else $error("positive mean gave negative word");
endmodule

// ### ssq_pkg.sv
// Shared constants, types and register map of the strain bridge sequencer
package ssq_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_CFG3 = 8'h0C;
  localparam logic [7:0] OFF_AVG = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_RES = 8'h1C;
  // Field positions
  localparam int POS_SINGLE = 2;
  localparam int POS_CYTIME = 4;
  localparam int POS_BRIDGE = 14;
  localparam int POS_MFAKE = 16;
  localparam int POS_ADJUST = 4;
  localparam int POS_STRETCH = 12;
  localparam int POS_LEAD = 17;
  localparam int POS_START = 0;
  localparam int POS_STOP = 1;
  // Reset values
  localparam logic [9:0] RST_CYTIME = 10'h050;
  localparam logic [9:0] RST_AVRATE = 10'h002;
  localparam logic [5:0] RST_ADJUST = 6'h04;
  localparam logic [2:0] RST_LEAD = 3'h1;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int FAST_STEP_NS = 2000;
  localparam int FAST_STEP_CYC = FAST_STEP_NS / CLK_PERIOD_NS;
  localparam int SLOW_STEP_US = 100;
  localparam int PAIR_GAP2_US = 200;
  localparam int PAIR_GAP3_US = 300;
  localparam logic [9:0] PAIR_GAP2_TICKS = 10'(PAIR_GAP2_US / SLOW_STEP_US);
  localparam logic [9:0] PAIR_GAP3_TICKS = 10'(PAIR_GAP3_US / SLOW_STEP_US);
  localparam int DISCH_TIMEOUT_US = 1000;
  localparam logic [19:0] DISCH_TIMEOUT_CYC = 20'(DISCH_TIMEOUT_US * 1000 / CLK_PERIOD_NS);
  localparam logic [4:0] COMP_CYCLES = 5'h06;
  localparam logic [4:0] TEMP_CYCLES = 5'h01;
  localparam logic [23:0] RES_MAX = 24'h7F_FFFF;
  localparam logic [23:0] RES_MIN = 24'h80_0000;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_WARM = 3'b001,
    ST_DISCH = 3'b010,
    ST_CHARGE = 3'b011,
    ST_GAP = 3'b100,
    ST_PAIR = 3'b101,
    ST_DIV = 3'b110
  } ssq_state_e;

  typedef struct packed {
    logic single_conv;
    logic [1:0] stretch;
    logic [9:0] cytime;
    logic [1:0] bridge;
    logic [1:0] mfake;
    logic [5:0] adjust;
    logic [2:0] lead;
    logic [9:0] avrate;
  } ssq_cfg_s;
endpackage

// ### ssq_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module ssq_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ### ssq_div.sv
// Sequential unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module ssq_div (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [35:0] dividend_i,
  input wire logic [9:0] divisor_i,
  output logic done_o,
  output logic [35:0] quotient_o
);
  logic [10:0] rem;
  logic [5:0] bit_cnt;
  logic busy;
  logic [10:0] trial;

  assign trial = {rem[9:0], quotient_o[35]};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rem <= '0;
      bit_cnt <= '0;
      busy <= 1'b0;
      done_o <= 1'b0;
      quotient_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        rem <= '0;
        quotient_o <= dividend_i;
        bit_cnt <= 6'd36;
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, divisor_i}) begin
          rem <= trial - {1'b0, divisor_i};
          quotient_o <= {quotient_o[34:0], 1'b1};
        end else begin
          rem <= trial;
          quotient_o <= {quotient_o[34:0], 1'b0};
        end
        bit_cnt <= bit_cnt - 6'd1;
        if (bit_cnt == 6'd1) begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ### ssq_bridge_model.sv
// Bridge, load capacitor and comparator seen from the sequencer pins
`timescale 1ns/10ps
module ssq_bridge_model (
  input wire logic clk_i,
  input wire logic discharge_i,
  input wire logic [2:0] gauge_sel_i,
  input wire logic [7:0][8:0] delay_i,
  output logic comp_trip_o
);
  logic [19:0] elapsed;

  // Each gauge discharges in its own time; trip holds until discharge ends
  always_ff @(posedge clk_i) begin
    if (!discharge_i) begin
      elapsed <= 20'h0_0000;
      comp_trip_o <= 1'b0;
    end else begin
      elapsed <= elapsed + 20'h0_0001;
      if (elapsed >= 20'(delay_i[gauge_sel_i])) begin
        comp_trip_o <= 1'b1;
      end
    end
  end
endmodule

// ### ssq_top_bench.sv
// Self-checking bench of the strain bridge sequencer
`timescale 1ns/10ps
module ssq_top_bench;
  localparam int PERIOD = ssq_pkg::FAST_STEP_CYC;
  localparam int TICK = 250;
  logic clk_i, reset_n_i, wr_en_i, rd_en_i, comp_trip_i, slow_osc_i;
  logic discharge_o, hs_osc_en_o, sleep_o, prev_dis, prev_osc, in_pair;
  logic [7:0] addr_i;
  logic [31:0] wr_data_i, rd_data_o, rdv;
  logic [2:0] gauge_sel_o;
  logic [7:0][8:0] dly;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int rises, gap_ok, osc_off, early, osc_falls, last_rise, pair_min, pair_max;

  ssq_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .comp_trip_i(comp_trip_i),
    .slow_osc_i(slow_osc_i), .discharge_o(discharge_o), .gauge_sel_o(gauge_sel_o),
    .hs_osc_en_o(hs_osc_en_o), .sleep_o(sleep_o));
  ssq_bridge_model partner (.clk_i(clk_i), .discharge_i(discharge_o), .gauge_sel_i(gauge_sel_o),
    .delay_i(dly), .comp_trip_o(comp_trip_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Slow ticks sped up to keep the run short; phase unrelated to clk_i
  initial begin
    slow_osc_i = 1'b0;
    forever #626.3 slow_osc_i = ~slow_osc_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (!sleep_o && !hs_osc_en_o) osc_off++;
    if (prev_osc && !hs_osc_en_o) begin
      osc_falls++;
      in_pair = 1'b0;
    end
    if (discharge_o && !prev_dis) begin
      rises++;
      if (cyc - last_rise == PERIOD) gap_ok++;
      if (!prev_osc) early++;
      if (in_pair && cyc - last_rise < pair_min) pair_min = cyc - last_rise;
      if (in_pair && cyc - last_rise > pair_max) pair_max = cyc - last_rise;
      in_pair = 1'b1;
      last_rise = cyc;
    end
    prev_dis = discharge_o;
    prev_osc = hs_osc_en_o;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 rdv = rd_data_o;
  endtask

  task automatic wait_sleep();
    int n;
    n = 0;
    while (sleep_o !== 1'b1 && n < 60000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 60000) begin
      chk("sleep_wait", 32'h1, 32'h0);
      report_and_stop();
    end
  endtask

  // Even gauges add, odd subtract; identical samples make the mean exact
  function automatic logic [31:0] exp_res(input int n);
    int s;
    s = 0;
    for (int g = 0; g < n; g++) s += (g % 2 == 0) ? int'(dly[g]) : -int'(dly[g]);
    return {8'h00, 24'(s)};
  endfunction

  task automatic run(input logic single, input int str, input int brg, input int mf, input int avg);
    int n, len, seqs, k;
    n = (brg == 0) ? 2 : (brg == 1) ? 4 : 8;
    seqs = single ? 1 : 2;
    len = avg * n + 6 + (1 << mf) + 1;
    for (int g = 0; g < 8; g++) dly[g] = 9'(20 + $urandom_range(0, 100));
    wr(ssq_pkg::OFF_MODE, (32'(single) << ssq_pkg::POS_SINGLE) | (32'(1) << ssq_pkg::POS_CYTIME)
      | (32'(brg) << ssq_pkg::POS_BRIDGE) | (32'(mf) << ssq_pkg::POS_MFAKE));
    wr(ssq_pkg::OFF_CFG3, (32'(2 * avg) << ssq_pkg::POS_ADJUST) | (32'(str) << ssq_pkg::POS_STRETCH)
      | (32'(1) << ssq_pkg::POS_LEAD));
    wr(ssq_pkg::OFF_AVG, 32'(avg));
    rises = 0;
    gap_ok = 0;
    osc_off = 0;
    early = 0;
    osc_falls = 0;
    pair_min = 1000000;
    pair_max = 0;
    wr(ssq_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    if (!single) begin
      k = 0;
      rdv = 32'h0000_0000;
      while (rdv[1] !== 1'b1 && k < 20000) begin
        rd(ssq_pkg::OFF_STAT);
        k++;
      end
      chk("first_seq", 32'h0000_0002, rdv & 32'h0000_0002);
      // Stop lands inside the second sequence, which must still finish
      wr(ssq_pkg::OFF_CTRL, 32'h0000_0002);
    end
    wait_sleep();
    chk("osc_asleep", 32'h0, {31'h0, hs_osc_en_o});
    rd(ssq_pkg::OFF_STAT);
    chk("status_new", 32'h0000_0006, rdv);
    rd(ssq_pkg::OFF_RES);
    chk("result", exp_res(n), rdv);
    rd(ssq_pkg::OFF_STAT);
    chk("status_read", 32'h0000_0004, rdv);
    chk("discharges", 32'(seqs * len), 32'(rises));
    if (str == 0) begin
      chk("osc_gaps", 32'h0, 32'(osc_off));
      if (single) chk("period", 32'(len - 1), 32'(gap_ok));
    end else begin
      chk("osc_lead", 32'h0, 32'(early));
      chk("osc_bursts", 32'((str == 1) ? rises : rises / 2), 32'(osc_falls));
      if (str > 1) chk("pair_gap", 32'h1, {31'h0, pair_min >= (str - 1) * TICK
        && pair_max <= (str + 1) * TICK + 300});
    end
  endtask

  initial begin
    #475000;
    chk("run_time", 32'h0, 32'h1);
    report_and_stop();
  end

  initial begin
    reset_n_i = 1'b0;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 32'h0000_0000;
    dly = '0;
    prev_dis = 1'b0;
    prev_osc = 1'b0;
    in_pair = 1'b0;
    void'($urandom(32'h24fc_2b6a));
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk("sleep_reset", 32'h1, {31'h0, sleep_o});
    rd(ssq_pkg::OFF_MODE);
    chk("mode_reset", 32'(ssq_pkg::RST_CYTIME) << ssq_pkg::POS_CYTIME, rdv);
    rd(ssq_pkg::OFF_CFG3);
    chk("cfg3_reset", (32'(ssq_pkg::RST_ADJUST) << ssq_pkg::POS_ADJUST)
      | (32'(ssq_pkg::RST_LEAD) << ssq_pkg::POS_LEAD), rdv);
    rd(ssq_pkg::OFF_AVG);
    chk("avg_reset", 32'(ssq_pkg::RST_AVRATE), rdv);
    rd(ssq_pkg::OFF_STAT);
    chk("status_reset", 32'h0000_0004, rdv);
    wr(8'h40, $urandom());
    rd(8'h40);
    chk("unmapped", 32'h0000_0000, rdv);
    rdv = $urandom();
    wr(ssq_pkg::OFF_CFG3, rdv);
    k_readback(rdv);
    for (int i = 0; i < 3; i++) run(1'b1, 0, i, i, 2 + 2 * $urandom_range(0, 1));
    run(1'b0, 0, 0, 3, 2);
    run(1'b0, 2, 0, 0, 2);
    for (int s = 1; s < 4; s++) run(1'b1, s, 0, 0, 2);
    report_and_stop();
  end

  task automatic k_readback(input logic [31:0] v);
    rd(ssq_pkg::OFF_CFG3);
    chk("cfg3_rw", v & 32'h000E_33F0, rdv);
  endtask
endmodule
